// ===== hdl/watchdog_interval_timer_ch1.sv
// Watchdog/interval timer channel 1 with keyed word-write register port.
// Assumes one system clock, synchronous inputs and a sampled sub-clock level.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_ch1_consts.svh"

module watchdog_interval_timer_ch1 (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_sub_clk,
	input wire logic i_ext_reset_pin,
	input wire logic i_wr_en,
	input wire logic i_wr_word,
	input wire logic [0:0] i_addr,
	input wire logic [15:0] i_wr_data,
	input wire logic i_rd_en,
	output logic [7:0] o_rd_data,
	output logic o_interval_irq,
	output logic o_nmi_req,
	output logic o_internal_reset,
	output logic o_reset_source_flag
);

	localparam int main_width = 17;
	localparam int sub_width = 8;

	// Divider exponents per clock select code
	localparam int main_exp [8] = '{1, 6, 7, 9, 11, 13, 15, 17};

	wdt_ch1_pkg::count_t watchdog_counter;
	logic [6:0] control;
	logic overflow_flag;
	logic clear_armed;
	logic [main_width-1:0] main_clock_prescaler;
	logic [sub_width-1:0] sub_clock_prescaler;
	logic sub_clk_q;
	wdt_ch1_pkg::wd_state_t state;
	logic [9:0] hold_count;

	logic timer_mode_select;
	logic count_enable_bit;
	logic prescaler_source_select;
	logic overflow_action;
	logic [2:0] clock_divide_sel;

	logic sub_edge;
	logic [7:0] main_tap;
	logic [7:0] sub_tap;
	logic tick;
	logic write_ok;
	logic counter_write;
	logic control_write;
	logic stop_write;
	logic overflow;
	logic watchdog_trip_reset;
	logic hold_done;
	logic next_overflow_flag;
	logic next_mode;
	logic [7:0] next_rd_data;
	wdt_ch1_pkg::count_t next_counter;
	logic status_read;
	logic watchdog_trip_nmi;

	assign timer_mode_select = control[`WDT_BIT_MODE];
	assign count_enable_bit = control[`WDT_BIT_ENABLE];
	assign prescaler_source_select = control[`WDT_BIT_PRESCALER];
	assign overflow_action = control[`WDT_BIT_ACTION];
	assign clock_divide_sel = control[`WDT_CKS_MSB:`WDT_CKS_LSB];

	// Keyed word writes; byte writes never land
	always_comb begin
		write_ok = 1'b0;
		counter_write = 1'b0;
		control_write = 1'b0;
		stop_write = 1'b0;
		if (i_wr_en && i_wr_word && (i_addr == `WDT_ADDR_CONTROL_STATUS)) begin
			write_ok = 1'b1;
		end
		if (write_ok) begin
			case (i_wr_data[15:8])
				`WDT_KEY_COUNTER: begin
					counter_write = 1'b1;
				end
				`WDT_KEY_CONTROL: begin
					control_write = 1'b1;
					stop_write = !i_wr_data[`WDT_BIT_ENABLE];
				end
				default: begin
					counter_write = 1'b0;
				end
			endcase
		end
	end

	// Sub-clock rising edge from the sampled level
	assign sub_edge = i_sub_clk && !sub_clk_q;

	// Tap pulses: low bits all ones means the divider wraps this cycle
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_tap
			localparam logic [main_width-1:0] main_mask = main_width'((33'h1 << main_exp[g]) - 33'h1);
			localparam logic [sub_width-1:0] sub_mask = sub_width'((9'h1 << (g + 1)) - 9'h1);
			assign main_tap[g] = ((main_clock_prescaler & main_mask) == main_mask);
			assign sub_tap[g] = sub_edge && ((sub_clock_prescaler & sub_mask) == sub_mask);
		end
	endgenerate

	// Selected prescaler output
	always_comb begin
		if (prescaler_source_select) begin
			tick = sub_tap[clock_divide_sel];
		end else begin
			tick = main_tap[clock_divide_sel];
		end
	end

	// Wrap only while counting and not overridden by a write
	always_comb begin
		overflow = 1'b0;
		if (count_enable_bit && !stop_write && !counter_write && tick) begin
			overflow = (watchdog_counter == `WDT_COUNTER_MAX);
		end
	end

	assign watchdog_trip_reset = overflow && timer_mode_select && overflow_action;
	assign watchdog_trip_nmi = overflow && timer_mode_select && !overflow_action;
	assign hold_done = (state == wdt_ch1_pkg::st_reset_hold) && (hold_count == `WDT_RESET_CYCLES - 10'h001);
	assign status_read = i_rd_en && (i_addr == `WDT_ADDR_CONTROL_STATUS);

	// Mode as it stands after this edge's write
	always_comb begin
		next_mode = timer_mode_select;
		if (control_write) begin
			next_mode = i_wr_data[`WDT_BIT_MODE];
		end
	end

	// Counter next value; a write beats a coinciding tick
	always_comb begin
		next_counter = watchdog_counter;
		if (stop_write || !count_enable_bit) begin
			next_counter = `WDT_COUNTER_RESET;
		end else if (counter_write) begin
			next_counter = i_wr_data[7:0];
		end else if (tick) begin
			next_counter = watchdog_counter + 8'h01;
		end
	end

	// Read mux: counter or flag with control bits
	always_comb begin
		if (i_addr == `WDT_ADDR_COUNTER) begin
			next_rd_data = watchdog_counter;
		end else begin
			next_rd_data = {overflow_flag, control};
		end
	end

	// Overflow flag next value; a new overflow beats every clear
	always_comb begin
		next_overflow_flag = overflow_flag;
		if (overflow) begin
			next_overflow_flag = 1'b1;
		end else if (stop_write) begin
			next_overflow_flag = 1'b0;
		end else if (control_write && clear_armed && !i_wr_data[`WDT_BIT_OVERFLOW]) begin
			next_overflow_flag = 1'b0;
		end else if (hold_done) begin
			next_overflow_flag = 1'b0;
		end
	end

	// Main-clock prescaler, free running
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			main_clock_prescaler <= '0;
		end else if (i_ce) begin
			main_clock_prescaler <= main_clock_prescaler + main_width'(1);
		end
	end

	// Sub-clock prescaler, steps on each sub-clock rising edge
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sub_clk_q <= 1'b0;
			sub_clock_prescaler <= '0;
		end else if (i_ce) begin
			sub_clk_q <= i_sub_clk;
			if (sub_edge) begin
				sub_clock_prescaler <= sub_clock_prescaler + sub_width'(1);
			end
		end
	end

	// Control bits
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			control <= `WDT_CONTROL_RESET;
		end else if (i_ce) begin
			if (control_write) begin
				control <= i_wr_data[6:0];
			end
		end
	end

	// Counter
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			watchdog_counter <= `WDT_COUNTER_RESET;
		end else if (i_ce) begin
			watchdog_counter <= next_counter;
		end
	end

	// Overflow flag and its read-before-clear arming
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			overflow_flag <= 1'b0;
			clear_armed <= 1'b0;
		end else if (i_ce) begin
			overflow_flag <= next_overflow_flag;
			if (!next_overflow_flag) begin
				clear_armed <= 1'b0;
			end else if (status_read && overflow_flag) begin
				clear_armed <= 1'b1;
			end
		end
	end

	// Interval request follows the flag in interval mode
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_interval_irq <= 1'b0;
		end else if (i_ce) begin
			o_interval_irq <= next_overflow_flag && !next_mode;
		end
	end

	// Non-maskable request pulse
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_nmi_req <= 1'b0;
		end else if (i_ce) begin
			o_nmi_req <= watchdog_trip_nmi;
		end
	end

	// Internal reset hold sequence
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state <= wdt_ch1_pkg::st_run;
			hold_count <= '0;
			o_internal_reset <= 1'b0;
		end else if (i_ce) begin
			case (state)
				wdt_ch1_pkg::st_run: begin
					hold_count <= '0;
					if (watchdog_trip_reset && !i_ext_reset_pin) begin
						state <= wdt_ch1_pkg::st_reset_hold;
						o_internal_reset <= 1'b1;
					end
				end
				wdt_ch1_pkg::st_reset_hold: begin
					if (i_ext_reset_pin || hold_done) begin
						state <= wdt_ch1_pkg::st_run;
						o_internal_reset <= 1'b0;
					end else begin
						hold_count <= hold_count + 10'h001;
					end
				end
				default: begin
					state <= wdt_ch1_pkg::st_run;
					o_internal_reset <= 1'b0;
				end
			endcase
		end
	end

	// Reset source: pin wins over a coinciding watchdog trip
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_reset_source_flag <= 1'b1;
		end else if (i_ce) begin
			if (i_ext_reset_pin) begin
				o_reset_source_flag <= 1'b1;
			end else if (watchdog_trip_reset && state == wdt_ch1_pkg::st_run) begin
				o_reset_source_flag <= 1'b0;
			end
		end
	end

	// Read port
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rd_data <= 8'h00;
		end else if (i_ce) begin
			if (i_rd_en) begin
				o_rd_data <= next_rd_data;
			end
		end
	end

endmodule // watchdog_interval_timer_ch1

`default_nettype wire

// ===== hdl/wdt_ch1_consts.svh
// Constants for watchdog/interval timer channel 1: offsets, fields, keys, counts.
// Assumes inclusion by bare name from the design file and the checker file.
`ifndef WDT_CH1_CONSTS_SVH
`define WDT_CH1_CONSTS_SVH

// Register addresses on the device port
`define WDT_ADDR_CONTROL_STATUS 1'h0
`define WDT_ADDR_COUNTER 1'h1

// Write keys carried in the upper byte
`define WDT_KEY_COUNTER 8'h5a
`define WDT_KEY_CONTROL 8'ha5

// Control/status field positions
`define WDT_BIT_OVERFLOW 7
`define WDT_BIT_MODE 6
`define WDT_BIT_ENABLE 5
`define WDT_BIT_PRESCALER 4
`define WDT_BIT_ACTION 3
`define WDT_CKS_MSB 2
`define WDT_CKS_LSB 0

// Reset values and counter maximum
`define WDT_CONTROL_RESET 7'h00
`define WDT_COUNTER_RESET 8'h00
`define WDT_COUNTER_MAX 8'hff

// Internal reset length in system clocks (518)
`define WDT_RESET_CYCLES 10'h206

`endif

// ===== hdl/wdt_ch1_pkg.sv
// Types for watchdog/interval timer channel 1.
// Assumes the constants header sits beside it.
`default_nettype none
package wdt_ch1_pkg;
	typedef enum {
		st_run,
		st_reset_hold
	} wd_state_t;

	typedef logic [7:0] count_t;
endpackage

`default_nettype wire

// ===== tb/watchdog_interval_timer_ch1_assertions.sv
// Port checks for watchdog/interval timer channel 1.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_ch1_consts.svh"
module watchdog_interval_timer_ch1_assertions (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_ext_reset_pin,
	input wire logic i_wr_en,
	input wire logic i_wr_word,
	input wire logic [0:0] i_addr,
	input wire logic [15:0] i_wr_data,
	input wire logic i_rd_en,
	input wire logic [7:0] o_rd_data,
	input wire logic o_interval_irq,
	input wire logic o_nmi_req,
	input wire logic o_internal_reset,
	input wire logic o_reset_source_flag
);
	logic [9:0] hold;
	logic ctl_wr;
	assign ctl_wr = i_ce && i_wr_en && i_wr_word && i_addr == 1'h0 && i_wr_data[15:8] == `WDT_KEY_CONTROL;
	// Cycles the internal reset has stood
	always_ff @(posedge i_clk) begin
		if (i_rst || !o_internal_reset) begin
			hold <= 10'h000;
		end else if (i_ce) begin
			hold <= hold + 10'h001;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	property p_reset_max; o_internal_reset |-> hold < `WDT_RESET_CYCLES; endproperty
	property p_reset_len; $fell(o_internal_reset) && !$past(i_ext_reset_pin) |-> hold == `WDT_RESET_CYCLES; endproperty
	property p_nmi_pulse; o_nmi_req && i_ce |=> !o_nmi_req; endproperty
	property p_irq_fall; $fell(o_interval_irq) |-> $past(ctl_wr || i_ext_reset_pin); endproperty
	property p_write_one; o_interval_irq && ctl_wr && i_wr_data[7:5] == 3'h5 |=> o_interval_irq; endproperty
	property p_tme_clear; ctl_wr && !i_wr_data[5] |=> !o_interval_irq && !o_nmi_req; endproperty
	property p_pin_wins; i_ext_reset_pin && i_ce |=> !o_internal_reset && o_reset_source_flag; endproperty
	property p_rd_hold; !(i_rd_en && i_ce) |=> $stable(o_rd_data); endproperty
	a_reset_max: assert property (p_reset_max) else $error("reset too long");
	a_reset_len: assert property (p_reset_len) else $error("reset length wrong");
	a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi not a pulse");
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
	a_write_one: assert property (p_write_one) else $error("write one cleared flag");
	a_tme_clear: assert property (p_tme_clear) else $error("enable off kept flag");
	a_pin_wins: assert property (p_pin_wins) else $error("pin reset lost");
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	c_nmi: cover property (o_nmi_req);
	c_reset: cover property ($rose(o_internal_reset));
	c_irq: cover property ($rose(o_interval_irq));
endmodule // watchdog_interval_timer_ch1_assertions
bind watchdog_interval_timer_ch1 watchdog_interval_timer_ch1_assertions u_checker (
	.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_ext_reset_pin(i_ext_reset_pin), .i_wr_en(i_wr_en),
	.i_wr_word(i_wr_word), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
	.o_interval_irq(o_interval_irq), .o_nmi_req(o_nmi_req), .o_internal_reset(o_internal_reset),
	.o_reset_source_flag(o_reset_source_flag));
`default_nettype wire

// ===== tb/watchdog_interval_timer_ch1_test.sv
// Bench for watchdog/interval timer channel 1.
// Assumes the design and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module watchdog_interval_timer_ch1_test;
	logic i_clk = 0, i_rst = 1, i_sub_clk = 0, i_ext_reset_pin = 0, i_wr_en = 0, i_wr_word = 0, i_rd_en = 0;
	logic i_ce = 1;
	logic [0:0] i_addr = 0;
	logic [15:0] i_wr_data = 0;
	logic [7:0] o_rd_data;
	logic o_interval_irq, o_nmi_req, o_internal_reset, o_reset_source_flag;
	int errors = 0, n_checks = 0, n;
	int per[4] = '{512, 16384, 4096, 16384};
	logic [7:0] ctl[4] = '{8'h20, 8'h21, 8'h30, 8'h32};
	wire [2:0] ev = {o_internal_reset, o_nmi_req, o_interval_irq};
	watchdog_interval_timer_ch1 u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_sub_clk(i_sub_clk),
		.i_ext_reset_pin(i_ext_reset_pin), .i_wr_en(i_wr_en), .i_wr_word(i_wr_word), .i_addr(i_addr),
		.i_wr_data(i_wr_data), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_interval_irq(o_interval_irq),
		.o_nmi_req(o_nmi_req), .o_internal_reset(o_internal_reset), .o_reset_source_flag(o_reset_source_flag));
	always #5 i_clk = ~i_clk;
	// Sub-clock rises every 8 system clocks
	always #40 i_sub_clk = ~i_sub_clk;
	task final_report;
		if (errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [15:0] d, input logic w);
		i_wr_data = d;
		i_wr_word = w;
		i_addr = 1'h0;
		i_wr_en = 1'h1;
		@(negedge i_clk);
		i_wr_en = 1'h0;
		@(negedge i_clk);
	endtask
	task rd(input logic a, input logic [7:0] e);
		i_addr = a;
		i_rd_en = 1'h1;
		@(negedge i_clk);
		i_rd_en = 1'h0;
		chk(o_rd_data, e);
		@(negedge i_clk);
	endtask
	task wait_ev(input int b, input logic v, input int lim);
		n = 0;
		while (ev[b] !== v && n < lim) begin
			@(negedge i_clk);
			n++;
		end
		if (n >= lim) chk(ev[b], v);
	endtask
	initial begin
		// About 70k cycles; the tests need roughly 40k
		#700000;
		errors++;
		final_report();
	end
	initial begin
		repeat (16) @(negedge i_clk);
		i_rst = 0;
		chk(o_reset_source_flag, 1);
		rd(1'h0, 8'h00);
		wr(16'ha520, 1'h0);
		wr(16'h3c20, 1'h1);
		rd(1'h0, 8'h00);
		wr(16'ha527, 1'h1);
		wr(16'h5a40, 1'h1);
		rd(1'h1, 8'h40);
		wr(16'ha500, 1'h1);
		rd(1'h1, 8'h00);
		wr(16'ha520, 1'h1);
		wr(16'h5aff, 1'h1);
		wait_ev(0, 1'h1, 20);
		wr(16'ha520, 1'h1);
		chk(o_interval_irq, 1);
		wr(16'ha5a0, 1'h1);
		chk(o_interval_irq, 1);
		rd(1'h0, 8'ha0);
		rd(1'h0, 8'ha0);
		wr(16'ha520, 1'h1);
		chk(o_interval_irq, 0);
		wait_ev(0, 1'h1, 600);
		wr(16'ha500, 1'h1);
		chk(o_interval_irq, 0);
		rd(1'h0, 8'h00);
		for (int k = 0; k < 4; k++) begin
			wr({8'ha5, ctl[k]}, 1'h1);
			wr(16'h5aff, 1'h1);
			wait_ev(0, 1'h1, 600);
			rd(1'h0, ctl[k] | 8'h80);
			wr({8'ha5, ctl[k]}, 1'h1);
			wait_ev(0, 1'h1, 20000);
			chk(n + 4, per[k]);
			wr(16'ha500, 1'h1);
		end
		wr(16'ha568, 1'h1);
		for (int k = 0; k < 6; k++) begin
			repeat (200) @(negedge i_clk);
			wr(16'h5a00, 1'h1);
		end
		chk(o_internal_reset, 0);
		rd(1'h0, 8'h68);
		wr(16'ha500, 1'h1);
		wr(16'ha560, 1'h1);
		wr(16'h5aff, 1'h1);
		wait_ev(1, 1'h1, 20);
		@(negedge i_clk);
		chk(o_nmi_req, 0);
		chk(o_interval_irq, 0);
		rd(1'h0, 8'he0);
		wr(16'ha500, 1'h1);
		wr(16'ha569, 1'h1);
		wr(16'h5aff, 1'h1);
		wait_ev(2, 1'h1, 200);
		// Frozen cycles must not count towards the hold
		i_ce = 0;
		repeat (100) @(negedge i_clk);
		i_ce = 1;
		chk(o_internal_reset, 1);
		wait_ev(2, 1'h0, 600);
		chk(n, 518);
		chk(o_reset_source_flag, 0);
		rd(1'h0, 8'h69);
		wr(16'h5aff, 1'h1);
		wait_ev(2, 1'h1, 200);
		repeat (3) @(negedge i_clk);
		i_ext_reset_pin = 1;
		@(negedge i_clk);
		i_ext_reset_pin = 0;
		chk(o_internal_reset, 0);
		chk(o_reset_source_flag, 1);
		wr(16'ha500, 1'h1);
		final_report();
	end
endmodule // watchdog_interval_timer_ch1_test
`default_nettype wire
